// *** design/anl_nexus_loss.sv ***
// nexus-loss event and acknowledgement time-out control for one port
// Summary of operation
// - sent login with option bit: event
// - received login with option bit: event
// - ack to our device reset: event
// - peer presence drops: event
// - reset service indication: event
// - closed during login or logged in: event
// - serial recomputes time-out on parameter change
// - new time-out used for later frames
// - tcp starts with 2.5 second time-out
// - tcp time-out replaced by time-out unit
// - automation side drives automation presence
// - drive side may drive drive presence
// - drive treats remote reset as reset
// - close returns state machine to initial
module anl_nexus_loss (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// configuration
	input wire logic drive_side,
	input wire logic interconnect_tcp,
	input wire logic drive_presence_enable,
	// transport events, one-cycle pulses
	input wire logic login_tx,
	input wire logic login_rx,
	input wire logic login_option_bit,
	input wire logic device_reset_tx,
	input wire logic ack_rx,
	input wire logic reset_indication,
	input wire logic closed_indication,
	input wire logic login_start,
	input wire logic login_done,
	// operating parameters
	input wire logic params_changed,
	input wire logic [31:0] baud_rate,
	input wire logic timeout_iu_valid,
	input wire logic [31:0] timeout_iu_cycles,
	// frame transmit
	input wire logic frame_tx,
	// pins
	input wire logic automation_presence_in,
	input wire logic drive_presence_in,
	input wire logic remote_reset_in,
	output logic automation_presence_out,
	output logic drive_presence_out,
	// status
	output logic nexus_loss,
	output logic [2:0] port_state,
	output logic [31:0] ack_timeout_cycles,
	output logic [31:0] frame_timeout_cycles,
	output logic reset_seen
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	// port state machine and events
	anl_pkg::anl_port_state_e state;
	anl_pkg::anl_port_state_e next_state;
	logic reset_pending;
	logic next_reset_pending;
	logic next_nexus_loss;
	logic next_reset_seen;
	// pin synchronisers
	logic sense_raw;
	logic sense_stable;
	logic sense_prev;
	logic rr_sync_1;
	logic rr_sync_2;
	logic rr_prev;
	logic rr_rise;
	// presence line outputs
	logic next_automation_presence;
	logic next_drive_presence;
	// time-out periods
	logic [31:0] serial_timeout;
	logic [31:0] tcp_timeout;
	logic [31:0] next_tcp_timeout;
	logic [31:0] active_timeout;
	logic [31:0] next_frame_timeout;
	logic tcp_prev;
	logic tcp_switch;

	// ----------------------------------------
	// presence sense
	// ----------------------------------------
	// pick the peer presence line
	// the other line is this port's own and is never watched
	assign sense_raw = drive_side ? automation_presence_in : drive_presence_in;

	anl_sense_filter u_sense (
		.clk(clk),
		.reset(reset),
		.sense_raw(sense_raw),
		.sense_stable(sense_stable)
	);

	// ----------------------------------------
	// time-out period
	// ----------------------------------------
	// tcp period lives below, so the timer keeps only the serial value
	anl_ack_timer u_timer (
		.clk(clk),
		.reset(reset),
		.interconnect_tcp(interconnect_tcp),
		.params_changed(params_changed),
		.baud_rate(baud_rate),
		.timeout_iu_valid(1'b0),
		.timeout_iu_cycles(32'h0),
		.ack_timeout_cycles(serial_timeout),
		.updated()
	);

	// tcp switch re-arms the fixed start value
	assign tcp_switch = interconnect_tcp & ~tcp_prev;
	assign rr_rise = rr_sync_2 & ~rr_prev;

	always_comb begin
		next_tcp_timeout = tcp_timeout;
		if (tcp_switch) begin
			next_tcp_timeout = anl_pkg::TCP_ACK_TIMEOUT_CYC;
		end else if (interconnect_tcp && timeout_iu_valid) begin
			next_tcp_timeout = timeout_iu_cycles;
		end
		active_timeout = interconnect_tcp ? next_tcp_timeout : serial_timeout;
		// frame takes the next value, so a tcp frame sent with a unit change uses it; a serial change reaches frames one cycle later
		next_frame_timeout = frame_timeout_cycles;
		if (frame_tx) begin
			next_frame_timeout = active_timeout;
		end
	end

	// ----------------------------------------
	// port state machine and event merge
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_reset_pending = reset_pending;
		if (closed_indication) begin
			next_state = anl_pkg::ANL_INITIAL_STATE;
		end else begin
			case (state)
				anl_pkg::ANL_INITIAL_STATE: begin
					if (login_start) begin
						next_state = anl_pkg::ANL_LOGIN_STATE;
					end
				end
				anl_pkg::ANL_LOGIN_STATE: begin
					if (login_done) begin
						next_state = anl_pkg::ANL_LOGGED_IN_STATE;
					end
				end
				anl_pkg::ANL_LOGGED_IN_STATE: begin
					next_state = anl_pkg::ANL_LOGGED_IN_STATE;
				end
				default: begin
					next_state = anl_pkg::ANL_INITIAL_STATE;
				end
			endcase
		end
		// ack consumes the pending reset; a new reset in the same cycle re-arms
		if (ack_rx) begin
			next_reset_pending = 1'b0;
		end
		if (device_reset_tx) begin
			next_reset_pending = 1'b1;
		end
	end

	// ----------------------------------------
	// nexus-loss cause merge
	// ----------------------------------------
	// one flop behind all causes, so coincident causes cannot double-pulse
	always_comb begin
		// all causes merge to one pulse
		next_nexus_loss = 1'b0;
		if (login_tx && login_option_bit) begin
			next_nexus_loss = 1'b1;
		end
		if (login_rx && login_option_bit) begin
			next_nexus_loss = 1'b1;
		end
		if (ack_rx && reset_pending) begin
			next_nexus_loss = 1'b1;
		end
		if (sense_prev && !sense_stable) begin
			next_nexus_loss = 1'b1;
		end
		if (reset_indication || (drive_side && rr_rise)) begin
			next_nexus_loss = 1'b1;
		end
		if (closed_indication && (state == anl_pkg::ANL_LOGIN_STATE || state == anl_pkg::ANL_LOGGED_IN_STATE)) begin
			next_nexus_loss = 1'b1;
		end
		next_reset_seen = reset_indication | (drive_side & rr_rise);
	end

	// ----------------------------------------
	// presence line next values
	// ----------------------------------------
	always_comb begin
		next_automation_presence = ~drive_side;
		next_drive_presence = drive_side & drive_presence_enable;
	end

	// ----------------------------------------
	// port state registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= anl_pkg::ANL_INITIAL_STATE;
			reset_pending <= 1'b0;
			port_state <= anl_pkg::ANL_INITIAL_STATE;
		end else begin
			state <= next_state;
			reset_pending <= next_reset_pending;
			// a copy of the state, so the port comes straight from a flop
			port_state <= next_state;
		end
	end

	// ----------------------------------------
	// pin synchronisers and edge history
	// ----------------------------------------
	// only rr_sync_2 reads rr_sync_1, so a metastable first stage never fans out
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sense_prev <= 1'b0;
			rr_sync_1 <= 1'b0;
			rr_sync_2 <= 1'b0;
			rr_prev <= 1'b0;
		end else begin
			sense_prev <= sense_stable;
			rr_sync_1 <= remote_reset_in;
			rr_sync_2 <= rr_sync_1;
			rr_prev <= rr_sync_2;
		end
	end

	// ----------------------------------------
	// event registers
	// ----------------------------------------
	// one-cycle pulses: the merge defaults them low every cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			nexus_loss <= 1'b0;
			reset_seen <= 1'b0;
		end else begin
			nexus_loss <= next_nexus_loss;
			reset_seen <= next_reset_seen;
		end
	end

	// ----------------------------------------
	// time-out registers
	// ----------------------------------------
	// tcp value kept apart, so a return to serial finds its own period
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tcp_timeout <= anl_pkg::TCP_ACK_TIMEOUT_CYC;
			tcp_prev <= 1'b0;
			ack_timeout_cycles <= anl_pkg::SERIAL_ACK_TIMEOUT_RESET;
			frame_timeout_cycles <= anl_pkg::SERIAL_ACK_TIMEOUT_RESET;
		end else begin
			tcp_timeout <= next_tcp_timeout;
			tcp_prev <= interconnect_tcp;
			ack_timeout_cycles <= active_timeout;
			frame_timeout_cycles <= next_frame_timeout;
		end
	end

	// ----------------------------------------
	// presence line registers
	// ----------------------------------------
	// registered so the lines never glitch while drive_side settles
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			automation_presence_out <= 1'b0;
			drive_presence_out <= 1'b0;
		end else begin
			automation_presence_out <= next_automation_presence;
			drive_presence_out <= next_drive_presence;
		end
	end
endmodule // anl_nexus_loss

// *** design/anl_pkg.sv ***
// constants for the nexus-loss and acknowledgement time-out block
package anl_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HZ = 100000000;
	// tcp start-up time-out, milliseconds
	localparam int TCP_ACK_TIMEOUT_MS = 2500;
	localparam longint TCP_ACK_TIMEOUT_CYC_L = longint'(TCP_ACK_TIMEOUT_MS) * longint'(CLK_HZ / 1000);
	localparam logic [31:0] TCP_ACK_TIMEOUT_CYC = TCP_ACK_TIMEOUT_CYC_L[31:0];
	// sense debounce, microseconds
	localparam int SENSE_DEBOUNCE_US = 10;
	localparam int SENSE_DEBOUNCE_CYC = SENSE_DEBOUNCE_US * 1000 / CLK_PERIOD_NS;
	localparam int DEB_W = 12;
	// serial time-out: cycles per bit time, times this many bit times
	localparam logic [31:0] SERIAL_ACK_BITS = 32'h0000_0C80;
	localparam logic [31:0] SERIAL_BAUD_RESET = 32'h0000_2580;
	localparam logic [31:0] SERIAL_ACK_TIMEOUT_RESET = 32'h0186_A000;
	// ----------------------------------------
	// port state machine
	// ----------------------------------------
	typedef enum logic [2:0] {
		ANL_INITIAL_STATE = 3'b001,
		ANL_LOGIN_STATE = 3'b010,
		ANL_LOGGED_IN_STATE = 3'b100
	} anl_port_state_e;
	// interconnect kinds
	localparam logic IC_SERIAL = 1'b0;
	localparam logic IC_TCP = 1'b1;
endpackage

// *** design/anl_sense_filter.sv ***
// synchroniser and debounce for a presence sense line
module anl_sense_filter (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// raw line and filtered level
	input wire logic sense_raw,
	output logic sense_stable
);
	logic sync_1;
	logic sync_2;
	logic [anl_pkg::DEB_W-1:0] count;
	logic [anl_pkg::DEB_W-1:0] next_count;
	logic next_stable;

	// ----------------------------------------
	// filter
	// ----------------------------------------
	always_comb begin
		next_count = count;
		next_stable = sense_stable;
		if (sync_2 == sense_stable) begin
			next_count = '0;
		end else if (count == anl_pkg::DEB_W'(anl_pkg::SENSE_DEBOUNCE_CYC - 1)) begin
			next_count = '0;
			next_stable = sync_2;
		end else begin
			next_count = count + 1'b1;
		end
	end

	// starts as absent, so a line present at reset never makes a false drop
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_1 <= 1'b0;
			sync_2 <= 1'b0;
			count <= '0;
			sense_stable <= 1'b0;
		end else begin
			sync_1 <= sense_raw;
			sync_2 <= sync_1;
			count <= next_count;
			sense_stable <= next_stable;
		end
	end
endmodule // anl_sense_filter

// *** design/anl_ack_timer.sv ***
// holds the active acknowledgement time-out period
module anl_ack_timer (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// configuration
	input wire logic interconnect_tcp,
	input wire logic params_changed,
	input wire logic [31:0] baud_rate,
	input wire logic timeout_iu_valid,
	input wire logic [31:0] timeout_iu_cycles,
	// result
	output logic [31:0] ack_timeout_cycles,
	output logic updated
);
	logic [31:0] next_timeout;
	logic next_updated;
	logic [31:0] bit_cycles;
	logic [63:0] product;

	always_comb begin
		bit_cycles = (baud_rate == 32'h0) ? 32'h0 : 32'(anl_pkg::CLK_HZ) / baud_rate;
		product = 64'(bit_cycles) * 64'(anl_pkg::SERIAL_ACK_BITS);
		next_timeout = ack_timeout_cycles;
		next_updated = 1'b0;
		if (interconnect_tcp) begin
			if (timeout_iu_valid) begin
				next_timeout = timeout_iu_cycles;
				next_updated = 1'b1;
			end
		end else if (params_changed) begin
			next_timeout = (product[63:32] != 32'h0) ? 32'hFFFF_FFFF : product[31:0];
			next_updated = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ack_timeout_cycles <= anl_pkg::SERIAL_ACK_TIMEOUT_RESET;
			updated <= 1'b0;
		end else begin
			ack_timeout_cycles <= next_timeout;
			updated <= next_updated;
		end
	end
endmodule // anl_ack_timer

// *** verif/anl_nexus_loss_chk.sv ***
// assertion checker for the nexus-loss block
module anl_nexus_loss_chk (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// configuration
	input wire logic drive_side,
	input wire logic interconnect_tcp,
	// transport events
	input wire logic login_tx,
	input wire logic login_rx,
	input wire logic login_option_bit,
	input wire logic device_reset_tx,
	input wire logic ack_rx,
	input wire logic reset_indication,
	input wire logic closed_indication,
	// operating parameters and frames
	input wire logic params_changed,
	input wire logic [31:0] baud_rate,
	input wire logic timeout_iu_valid,
	input wire logic [31:0] timeout_iu_cycles,
	input wire logic frame_tx,
	// pins
	input wire logic remote_reset_in,
	// outputs
	input wire logic nexus_loss,
	input wire logic reset_seen,
	input wire logic [2:0] port_state,
	input wire logic [31:0] ack_timeout_cycles,
	input wire logic [31:0] frame_timeout_cycles
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// multi-step causes
	// ----------------------------------------
	sequence s_reset_acked;
		device_reset_tx ##1 ack_rx;
	endsequence
	sequence s_remote_rise;
		drive_side && !remote_reset_in ##1 remote_reset_in;
	endsequence
	a_login_loss: assert property ((login_tx || login_rx) && login_option_bit |=> nexus_loss)
		else $error("login with option bit gave no event");
	a_ack_loss: assert property (s_reset_acked |=> nexus_loss)
		else $error("acked device reset gave no event");
	a_reset_loss: assert property (reset_indication |=> nexus_loss && reset_seen)
		else $error("reset indication gave no event");
	a_close_loss: assert property (closed_indication && !port_state[0] |=> nexus_loss)
		else $error("close while logging in gave no event");
	a_close_init: assert property (closed_indication |=> port_state == 3'h1)
		else $error("close did not return to initial");
	a_serial_calc: assert property (!interconnect_tcp && params_changed |=> ##1
		ack_timeout_cycles == anl_pkg::CLK_HZ / $past(baud_rate, 2) * anl_pkg::SERIAL_ACK_BITS)
		else $error("serial period wrong");
	a_tcp_start: assert property ($rose(interconnect_tcp) |-> ##[1:3]
		ack_timeout_cycles == anl_pkg::TCP_ACK_TIMEOUT_CYC)
		else $error("tcp start period wrong");
	a_tcp_unit: assert property (interconnect_tcp && $past(interconnect_tcp) && timeout_iu_valid
		|=> ack_timeout_cycles == $past(timeout_iu_cycles))
		else $error("time-out unit not applied");
	// frame and active period load from the same next value
	a_frame_use: assert property (frame_tx |=> frame_timeout_cycles == ack_timeout_cycles)
		else $error("frame did not take period");
	a_remote_seen: assert property (s_remote_rise |-> ##[1:6] reset_seen)
		else $error("remote reset not seen");
endmodule // anl_nexus_loss_chk

bind anl_nexus_loss anl_nexus_loss_chk u_chk (.clk, .reset, .drive_side, .interconnect_tcp, .login_tx,
	.login_rx, .login_option_bit, .device_reset_tx, .ack_rx, .reset_indication, .closed_indication,
	.params_changed, .timeout_iu_valid, .frame_tx, .remote_reset_in, .baud_rate, .timeout_iu_cycles,
	.nexus_loss, .reset_seen, .port_state, .ack_timeout_cycles, .frame_timeout_cycles);

// *** verif/anl_peer_model.sv ***
// peer port model driving the sense and remote reset lines
module anl_peer_model (
	// clock
	input wire logic clk,
	// block role and its own presence outputs
	input wire logic dut_drive_side,
	input wire logic dut_aut_out,
	input wire logic dut_drv_out,
	// commands from the bench
	input wire logic peer_present,
	input wire logic peer_reset_req,
	// lines seen by the block
	output logic automation_presence_in,
	output logic drive_presence_in,
	output logic remote_reset_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {automation_presence_in, drive_presence_in, remote_reset_in} = 3'h0;
	always @(posedge clk) begin
		automation_presence_in <= dut_drive_side ? peer_present : dut_aut_out;
		drive_presence_in <= dut_drive_side ? dut_drv_out : peer_present;
		remote_reset_in <= dut_drive_side && peer_reset_req;
	end
endmodule // anl_peer_model

// *** verif/anl_nexus_loss_tb.sv ***
// self-checking bench for the nexus-loss block
module anl_nexus_loss_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, reset = 1'b1, drive_side = 1'b1, interconnect_tcp = 1'b0;
	logic drive_presence_enable = 1'b1, login_option_bit = 1'b0, peer_present = 1'b1, peer_reset_req = 1'b0;
	logic [10:0] ev = 11'h000;
	logic [31:0] baud_rate = 32'h2580, timeout_iu_cycles = 32'h0, exp;
	logic login_tx, login_rx, device_reset_tx, ack_rx, reset_indication, closed_indication;
	logic login_start, login_done, params_changed, timeout_iu_valid, frame_tx, o;
	logic automation_presence_in, drive_presence_in, remote_reset_in;
	logic automation_presence_out, drive_presence_out, nexus_loss, reset_seen;
	logic [2:0] port_state;
	logic [31:0] ack_timeout_cycles, frame_timeout_cycles;
	logic [1:0] r;
	int miscompares = 0, num_checks = 0, nl_cnt = 0, c0, i;
	integer seed = 32'h0514;
	logic [31:0] bauds[5] = '{32'h2580, 32'h4B00, 32'h9600, 32'hE100, 32'h1C200};
	`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
		$display("Error %s expected %0h seen %0h", n, e, a); end end
	// events as one vector so a task can pulse any mix
	assign {frame_tx, timeout_iu_valid, params_changed, login_done, login_start, closed_indication,
		reset_indication, ack_rx, device_reset_tx, login_rx, login_tx} = ev;
	anl_nexus_loss dut (.clk, .reset, .drive_side, .interconnect_tcp, .drive_presence_enable, .login_tx,
		.login_rx, .login_option_bit, .device_reset_tx, .ack_rx, .reset_indication, .closed_indication,
		.login_start, .login_done, .params_changed, .baud_rate, .timeout_iu_valid, .timeout_iu_cycles,
		.frame_tx, .automation_presence_in, .drive_presence_in, .remote_reset_in, .automation_presence_out,
		.drive_presence_out, .nexus_loss, .port_state, .ack_timeout_cycles, .frame_timeout_cycles, .reset_seen);
	anl_peer_model peer (.clk, .dut_drive_side(drive_side), .dut_aut_out(automation_presence_out),
		.dut_drv_out(drive_presence_out), .peer_present, .peer_reset_req, .automation_presence_in,
		.drive_presence_in, .remote_reset_in);
	initial forever #5 clk = ~clk;
	always @(posedge clk) if (nexus_loss === 1'b1) nl_cnt <= nl_cnt + 1;
	function automatic logic [31:0] ser_to(input logic [31:0] b);
		return anl_pkg::CLK_HZ / b * anl_pkg::SERIAL_ACK_BITS;
	endfunction
	task automatic end_sim;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// optional second vector lands on the very next cycle
	task automatic fire(input logic [10:0] v, input logic e, input logic [10:0] v2 = 11'h000);
		@(posedge clk) ev <= v;
		if (v2 != 11'h000) @(posedge clk) ev <= v2;
		@(posedge clk) ev <= 11'h000;
		#1 `CHK("nexus_loss", e, nexus_loss)
	endtask
	task automatic wait_nl(input int lim);
		c0 = nl_cnt;
		for (i = 0; i < lim && nl_cnt == c0; i++) @(posedge clk) #1;
		if (nl_cnt == c0) begin miscompares++; end_sim; end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		#1 `CHK("state", 3'h1, port_state)
		`CHK("ack", anl_pkg::SERIAL_ACK_TIMEOUT_RESET, ack_timeout_cycles)
		repeat (12) begin
			o = $random(seed);
			r = $random(seed);
			login_option_bit <= o;
			fire({9'h000, r}, o && r != 2'h0);
		end
		fire(11'h008, 1'b0);
		fire(11'h004, 1'b1, 11'h008);
		fire(11'h008, 1'b0);
		fire(11'h010, 1'b1);
		`CHK("reset_seen", 1'b1, reset_seen)
		$display("done causes");
		fire(11'h020, 1'b0);
		fire(11'h040, 1'b1, 11'h020);
		`CHK("state", 3'h1, port_state)
		fire(11'h040, 1'b0, 11'h080);
		`CHK("state", 3'h4, port_state)
		fire(11'h0A0, 1'b1);
		`CHK("state", 3'h1, port_state)
		login_option_bit <= 1'b1;
		// the last pulse is counted one edge after it shows
		@(posedge clk) #1 c0 = nl_cnt;
		fire(11'h013, 1'b1);
		repeat (3) @(posedge clk);
		#1 `CHK("pulses", c0 + 1, nl_cnt)
		$display("done close");
		foreach (bauds[k]) begin
			exp = ser_to(bauds[k]);
			baud_rate <= bauds[k];
			fire(11'h100, 1'b0);
			@(posedge clk) #1 `CHK("ack", exp, ack_timeout_cycles)
			fire(11'h400, 1'b0);
			`CHK("frame", exp, frame_timeout_cycles)
		end
		interconnect_tcp <= 1'b1;
		repeat (4) @(posedge clk);
		#1 `CHK("ack", anl_pkg::TCP_ACK_TIMEOUT_CYC, ack_timeout_cycles)
		exp = $random(seed);
		timeout_iu_cycles <= exp;
		fire(11'h200, 1'b0);
		`CHK("ack", exp, ack_timeout_cycles)
		fire(11'h500, 1'b0);
		`CHK("frame", exp, frame_timeout_cycles)
		interconnect_tcp <= 1'b0;
		$display("done timeout");
		// filter starts at absent, so let it settle
		repeat (1100) @(posedge clk);
		#1 `CHK("aut_out", 1'b0, automation_presence_out)
		`CHK("drv_out", 1'b1, drive_presence_out)
		c0 = nl_cnt;
		peer_present <= 1'b0;
		repeat (500) @(posedge clk);
		peer_present <= 1'b1;
		repeat (1200) @(posedge clk);
		#1 `CHK("glitch", c0, nl_cnt)
		peer_present <= 1'b0;
		wait_nl(1100);
		peer_present <= 1'b1;
		peer_reset_req <= 1'b1;
		wait_nl(8);
		peer_reset_req <= 1'b0;
		drive_presence_enable <= 1'b0;
		repeat (3) @(posedge clk);
		#1 `CHK("drv_out", 1'b0, drive_presence_out)
		drive_side <= 1'b0;
		repeat (1100) @(posedge clk);
		#1 `CHK("aut_out", 1'b1, automation_presence_out)
		peer_present <= 1'b0;
		wait_nl(1100);
		$display("done sense");
		end_sim;
	end
endmodule // anl_nexus_loss_tb
